// >>> common/serial_unit_defs.vh
// Register indices, reset values, field positions and codes of the serial unit front end
`ifndef SERIAL_UNIT_DEFS_VH
`define SERIAL_UNIT_DEFS_VH

// Register indices (byte address is four times the index)
`define IDX_DATA_BUFFER   16'hf600
`define IDX_MODE_SELECT   16'hf602
`define IDX_FRAME_GAP     16'hf604
`define IDX_ENABLE        16'hf606
`define IDX_SYNC_CONFIG   16'hf608
`define ADDR_WIDTH        18

// Reset values
`define RST_DATA_BUFFER   16'h0000
`define RST_MODE_SELECT   8'h00
`define RST_FRAME_GAP     8'h00
`define RST_ENABLE        16'h0000
`define RST_BUF_LOW       8'h00
`define RST_BUF_HIGH      8'h00

// Mode select fields
`define MOD_INTS_BIT      7
`define MOD_TIMD_BIT      6
`define MOD_RIMD_BIT      5
`define MOD_MASK          8'he3

// Communication mode codes (bit 1 and bit 0 of mode select)
`define CM_SYNC0          2'b00
`define CM_SYNC1          2'b01
`define CM_UART_FULL      2'b10
`define CM_UART_HALF      2'b11

// Enable register fields
`define EN_SYNC_BIT       0
`define EN_CH0_BIT        1
`define EN_CH1_BIT        9

// Sync configuration fields
`define CFG_LEN_BIT       3

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// Frame gap offset added to the programmed value
`define GAP_OFFSET        17'h00002

`endif

// >>> hdl/serial_unit_buffer_mode_interval.v
// Serial unit front end: data buffer, mode select, interrupt timing and frame gap
// Operation
// - Mode field 00/01 sync serial, 10 UART full-duplex, 11 half-duplex; resets 00.
// - Sync serial: buffer write loads transmit shift register; read returns receive holding.
// - Sync 8-bit: upper byte unused; lower-byte write starts the operation.
// - Sync 16-bit: both bytes carry data; upper-byte write starts the operation.
// - Full-duplex: lower byte is receive buffer, upper byte transmit buffer.
// - Full-duplex: received character overwrites lower byte and raises channel 0 interrupt.
// - Full-duplex: CPU writes to the lower byte are ignored.
// - Short characters: unused receive bits read zero, unused transmit bits dropped.
// - UART: transmit data in the upper byte stays readable.
// - Half-duplex: low byte channel 0, high byte channel 1; receive raises channel interrupt.
// - Half-duplex: writes to a byte ignored while its channel receives.
// - Transmit timing bit with style bit selects end, start and end, or start only.
// - Receive timing bit behaves likewise; zero always interrupts at reception end.
// - Frame gap value zero inserts no idle gap between frames.
// - Sync gap is transfer-clock periods times ceil((value+2)/division ratio).
// - UART gap is base clock times (divisor+1) times ceil((value+2)/(divisor+1)).
// - Frame gap has no effect as sync master in receive-only mode.
// - Enable bits 0, 1 and 9; writes to bits not valid in current mode ignored.
// - Sync length bit zero selects 8-bit, one selects 16-bit transfers.
`default_nettype none
`include "serial_unit_defs.vh"

module serial_unit_buffer_mode_interval (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_b,
  // AXI4-Lite slave
  input  wire [`ADDR_WIDTH-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`ADDR_WIDTH-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Context from shifter and UART blocks
  input  wire                    sync_master,
  input  wire                    sync_rx_only,
  input  wire                    ch0_direction,
  input  wire                    ch1_direction,
  input  wire [3:0]              char_bits0,
  input  wire [3:0]              char_bits1,
  // Receive data and events
  input  wire [15:0]             rx_holding_register,
  input  wire [1:0]              rx_done,
  input  wire [7:0]              rx_data0,
  input  wire [7:0]              rx_data1,
  input  wire [1:0]              rx_start_evt,
  input  wire [1:0]              tx_start_evt,
  input  wire [1:0]              tx_end_evt,
  // Frame gap timing
  input  wire                    tx_frame_end,
  input  wire                    gap_tick,
  input  wire [15:0]             sync_div_ratio,
  input  wire [15:0]             baud_divisor,
  // Outputs to shifter and UART blocks
  output reg  [15:0]             tx_shift_register,
  output reg                     sync_load,
  output reg                     sync_op_start,
  output reg  [1:0]              uart_tx_load,
  output reg  [7:0]              buffer_low_byte,
  output reg  [7:0]              buffer_high_byte,
  output reg  [1:0]              comm_mode,
  output reg                     sync_length_select,
  output reg                     sync_serial_start,
  output reg                     uart_ch0_start,
  output reg                     uart_ch1_start,
  output reg                     channel0_interrupt,
  output reg                     channel1_interrupt,
  output reg                     frame_gap_active
);

  reg  [7:0]              mode_r;
  reg  [7:0]              gap_r;
  reg  [`ADDR_WIDTH-1:0]  waddr_r;
  reg  [15:0]             wdata_r;
  reg  [1:0]              wstrb_r;
  reg                     have_aw_r;
  reg                     have_w_r;
  reg  [16:0]             gap_cnt_r;
  reg  [16:0]             gap_ph_r;
  reg  [31:0]             rdata_nxt;
  reg                     rmapped;
  reg  [7:0]              lo_nxt;
  reg  [7:0]              hi_nxt;
  reg                     irq0_nxt;
  reg                     irq1_nxt;

  wire [1:0]  cm         = mode_r[1:0];
  wire        is_sync    = (cm == `CM_SYNC0) || (cm == `CM_SYNC1);
  wire        is_full    = (cm == `CM_UART_FULL);
  wire        is_half    = (cm == `CM_UART_HALF);
  wire        ints       = mode_r[`MOD_INTS_BIT];
  wire        timd       = mode_r[`MOD_TIMD_BIT];
  wire        rimd       = mode_r[`MOD_RIMD_BIT];
  wire [7:0]  mask0      = len_mask(char_bits0);
  wire [7:0]  mask1      = len_mask(char_bits1);
  wire        do_write   = have_aw_r && have_w_r && !s_axi_bvalid;
  wire [15:0] widx       = waddr_r[`ADDR_WIDTH-1:2];
  wire [15:0] ridx       = s_axi_araddr[`ADDR_WIDTH-1:2];
  wire        wr_buf     = do_write && (widx == `IDX_DATA_BUFFER);
  wire        wr_lo      = wr_buf && wstrb_r[0];
  wire        wr_hi      = wr_buf && wstrb_r[1];
  wire        w_mapped   = (widx == `IDX_DATA_BUFFER) || (widx == `IDX_MODE_SELECT) ||
                           (widx == `IDX_FRAME_GAP) || (widx == `IDX_ENABLE) ||
                           (widx == `IDX_SYNC_CONFIG);
  wire        rd_take    = s_axi_arvalid && s_axi_arready;
  wire [16:0] gap_mod    = is_sync ? {1'b0, sync_div_ratio} : ({1'b0, baud_divisor} + 17'h00001);
  wire [16:0] gap_target = {9'h000, gap_r} + `GAP_OFFSET;
  wire [16:0] gap_cnt_inc = gap_cnt_r + 17'h00001;
  wire        gap_exempt = is_sync && sync_master && sync_rx_only;

  // Bits above the character length read and write as zero
  function [7:0] len_mask;
    input [3:0] bits;
    begin
      if (bits >= 4'd8) begin
        len_mask = 8'hff;
      end else begin
        len_mask = 8'hff >> (4'd8 - bits);
      end
    end
  endfunction

  // Write channel capture; one write in flight, ready drops until the response is taken
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      have_aw_r     <= 1'b0;
      have_w_r      <= 1'b0;
      waddr_r       <= {`ADDR_WIDTH{1'b0}};
      wdata_r       <= 16'h0000;
      wstrb_r       <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_r       <= s_axi_awaddr;
        have_aw_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata[15:0];
        wstrb_r      <= s_axi_wstrb[1:0];
        have_w_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        have_aw_r    <= 1'b0;
        have_w_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read data selection
  always @* begin
    rdata_nxt = 32'h00000000;
    rmapped   = 1'b1;
    case (ridx)
      `IDX_DATA_BUFFER: begin
        if (is_sync) begin
          rdata_nxt[7:0] = rx_holding_register[7:0];
          if (sync_length_select) begin
            rdata_nxt[15:8] = rx_holding_register[15:8];
          end
        end else if (is_full) begin
          rdata_nxt[7:0]  = buffer_low_byte & mask0;
          rdata_nxt[15:8] = buffer_high_byte;
        end else begin
          rdata_nxt[7:0]  = buffer_low_byte & mask0;
          rdata_nxt[15:8] = buffer_high_byte & mask1;
        end
      end
      `IDX_MODE_SELECT: rdata_nxt[7:0] = mode_r & `MOD_MASK;
      `IDX_FRAME_GAP:   rdata_nxt[7:0] = gap_r;
      `IDX_ENABLE: begin
        rdata_nxt[`EN_SYNC_BIT] = sync_serial_start;
        rdata_nxt[`EN_CH0_BIT]  = uart_ch0_start;
        rdata_nxt[`EN_CH1_BIT]  = uart_ch1_start;
      end
      `IDX_SYNC_CONFIG: rdata_nxt[`CFG_LEN_BIT] = sync_length_select;
      default:          rmapped = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_rdata   <= rdata_nxt;
        s_axi_rresp   <= rmapped ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Control registers; enable bits outside the current mode keep their value
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r             <= `RST_MODE_SELECT;
      gap_r              <= `RST_FRAME_GAP;
      sync_serial_start  <= 1'b0;
      uart_ch0_start     <= 1'b0;
      uart_ch1_start     <= 1'b0;
      sync_length_select <= 1'b0;
    end else if (do_write && wstrb_r[0] && (widx == `IDX_MODE_SELECT)) begin
      mode_r <= wdata_r[7:0] & `MOD_MASK;
    end else if (do_write && wstrb_r[0] && (widx == `IDX_FRAME_GAP)) begin
      gap_r <= wdata_r[7:0];
    end else if (do_write && wstrb_r[0] && (widx == `IDX_SYNC_CONFIG)) begin
      sync_length_select <= wdata_r[`CFG_LEN_BIT];
    end else if (do_write && (widx == `IDX_ENABLE)) begin
      if (wstrb_r[0] && is_sync) begin
        sync_serial_start <= wdata_r[`EN_SYNC_BIT];
      end
      if (wstrb_r[0] && !is_sync) begin
        uart_ch0_start <= wdata_r[`EN_CH0_BIT];
      end
      if (wstrb_r[1] && is_half) begin
        uart_ch1_start <= wdata_r[`EN_CH1_BIT];
      end
    end
  end

  always @* begin
    comm_mode = cm;
  end

  // Buffer bytes: receive stores take the byte when the CPU write to it is blocked anyway
  always @* begin
    lo_nxt = buffer_low_byte;
    hi_nxt = buffer_high_byte;
    if (is_sync) begin
      if (wr_lo) begin
        lo_nxt = wdata_r[7:0];
      end
      if (wr_hi && sync_length_select) begin
        hi_nxt = wdata_r[15:8];
      end
    end else if (is_full) begin
      if (rx_done[0]) begin
        lo_nxt = rx_data0 & mask0;
      end
      if (wr_hi) begin
        hi_nxt = wdata_r[15:8] & mask0;
      end
    end else begin
      if (rx_done[0] && !ch0_direction) begin
        lo_nxt = rx_data0 & mask0;
      end else if (wr_lo && ch0_direction) begin
        lo_nxt = wdata_r[7:0] & mask0;
      end
      if (rx_done[1] && !ch1_direction) begin
        hi_nxt = rx_data1 & mask1;
      end else if (wr_hi && ch1_direction) begin
        hi_nxt = wdata_r[15:8] & mask1;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_low_byte   <= `RST_BUF_LOW;
      buffer_high_byte  <= `RST_BUF_HIGH;
      tx_shift_register <= `RST_DATA_BUFFER;
      sync_load         <= 1'b0;
      sync_op_start     <= 1'b0;
      uart_tx_load      <= 2'b00;
    end else begin
      buffer_low_byte  <= lo_nxt;
      buffer_high_byte <= hi_nxt;
      sync_load        <= is_sync && (wr_lo || (wr_hi && sync_length_select));
      sync_op_start    <= is_sync && (sync_length_select ? wr_hi : wr_lo);
      if (is_sync && (wr_lo || wr_hi)) begin
        tx_shift_register <= {(sync_length_select ? hi_nxt : 8'h00), lo_nxt};
      end
      uart_tx_load[0] <= (is_full && wr_hi) || (is_half && wr_lo && ch0_direction);
      uart_tx_load[1] <= is_half && wr_hi && ch1_direction;
    end
  end

  // Interrupt timing: start fires when the timing bit is set, end unless style selects start only
  always @* begin
    irq0_nxt = 1'b0;
    irq1_nxt = 1'b0;
    case (cm)
      `CM_SYNC0, `CM_SYNC1: begin
        irq0_nxt = (tx_start_evt[0] && timd) || (tx_end_evt[0] && !(ints && timd)) ||
                   (rx_start_evt[0] && rimd) || (rx_done[0] && !(ints && rimd));
      end
      `CM_UART_FULL: begin
        irq0_nxt = (rx_start_evt[0] && rimd) || (rx_done[0] && !(ints && rimd));
        irq1_nxt = (tx_start_evt[0] && timd) || (tx_end_evt[0] && !(ints && timd));
      end
      `CM_UART_HALF: begin
        irq0_nxt = (tx_start_evt[0] && timd) || (tx_end_evt[0] && !(ints && timd)) ||
                   (rx_start_evt[0] && rimd) || (rx_done[0] && !(ints && rimd));
        irq1_nxt = (tx_start_evt[1] && timd) || (tx_end_evt[1] && !(ints && timd)) ||
                   (rx_start_evt[1] && rimd) || (rx_done[1] && !(ints && rimd));
      end
      default: begin
        irq0_nxt = 1'b0;
        irq1_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel0_interrupt <= 1'b0;
      channel1_interrupt <= 1'b0;
    end else begin
      channel0_interrupt <= irq0_nxt;
      channel1_interrupt <= irq1_nxt;
    end
  end

  // Frame gap: ticks until a whole number of periods covers value plus offset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_gap_active <= 1'b0;
      gap_cnt_r        <= 17'h00000;
      gap_ph_r         <= 17'h00000;
    end else if (tx_frame_end && (gap_r != 8'h00) && !gap_exempt) begin
      frame_gap_active <= 1'b1;
      gap_cnt_r        <= 17'h00000;
      gap_ph_r         <= 17'h00000;
    end else if (frame_gap_active && gap_tick) begin
      gap_cnt_r <= gap_cnt_inc;
      if ((gap_ph_r + 17'h00001) >= gap_mod) begin
        gap_ph_r <= 17'h00000;
        if (gap_cnt_inc >= gap_target) begin
          frame_gap_active <= 1'b0;
        end
      end else begin
        gap_ph_r <= gap_ph_r + 17'h00001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> sim/serial_far_side.sv
// Far-side model: receive, transmit and frame events toward the unit
`default_nettype none
module serial_far_side (
  // Clock
  input  wire logic       clk,
  // Events toward the unit
  output logic [1:0]      rx_done,
  output logic [7:0]      rx_data0,
  output logic [7:0]      rx_data1,
  output logic [1:0]      rx_start_evt,
  output logic [1:0]      tx_start_evt,
  output logic [1:0]      tx_end_evt,
  output logic            tx_frame_end,
  output logic            gap_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick_per = 1;
  int tick_cnt = 0;
  initial begin
    {rx_done, rx_start_evt, tx_start_evt, tx_end_evt} = 8'h00;
    {rx_data0, rx_data1} = 16'h0000;
    tx_frame_end = 1'b0;
    gap_tick = 1'b0;
  end
  // Slow source clock so a gap spans many system cycles
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt + 1 >= tick_per) ? 0 : tick_cnt + 1;
    gap_tick <= (tick_cnt + 1 >= tick_per);
  end
  // Data are valid only with the strobe; inverted after so stale values show
  task automatic evt(input int kind, input int ch, input logic [7:0] d);
    @(posedge clk);
    case (kind)
      0: rx_done[ch] <= 1'b1;
      1: rx_start_evt[ch] <= 1'b1;
      2: tx_start_evt[ch] <= 1'b1;
      3: tx_end_evt[ch] <= 1'b1;
      default: tx_frame_end <= 1'b1;
    endcase
    rx_data0 <= d;
    rx_data1 <= d;
    @(posedge clk);
    {rx_done, rx_start_evt, tx_start_evt, tx_end_evt} <= 8'h00;
    tx_frame_end <= 1'b0;
    rx_data0 <= ~d;
    rx_data1 <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> sim/serial_unit_buffer_mode_interval_tb_top.sv
// Testbench for the serial unit front end
`default_nettype none
`include "serial_unit_defs.vh"
module serial_unit_buffer_mode_interval_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_BUF = `IDX_DATA_BUFFER * 4;
  localparam logic [17:0] A_MOD = `IDX_MODE_SELECT * 4;
  localparam logic [17:0] A_GAP = `IDX_FRAME_GAP * 4;
  localparam logic [17:0] A_EN  = `IDX_ENABLE * 4;
  localparam logic [17:0] A_CFG = `IDX_SYNC_CONFIG * 4;
  localparam logic [1:0]  OK    = `RESP_OKAY;
  typedef struct packed {logic [17:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;} row_t;
  typedef struct packed {logic [7:0] m; logic [7:0] g; logic [15:0] dv; logic ro; int n;} gap_t;
  localparam row_t rows[12] = '{
    '{A_MOD, 16'h00ff, 16'h00e3, OK}, '{A_EN, 16'h0203, 16'h0202, OK},
    '{A_EN, 16'h0000, 16'h0000, OK}, '{A_MOD, 16'h0002, 16'h0002, OK},
    '{A_EN, 16'h0203, 16'h0002, OK}, '{A_EN, 16'h0000, 16'h0000, OK},
    '{A_MOD, 16'h0001, 16'h0001, OK}, '{A_EN, 16'h0203, 16'h0001, OK},
    '{A_EN, 16'h0000, 16'h0000, OK}, '{A_GAP, 16'h00a5, 16'h00a5, OK},
    '{A_CFG, 16'h0008, 16'h0008, OK}, '{18'h3d830, 16'h1234, 16'h0000, `RESP_SLVERR}};
  localparam gap_t gaps[6] = '{'{8'h00, 8'h03, 16'd2, 1'b0, 6}, '{8'h02, 8'h03, 16'd3, 1'b0, 8},
    '{8'h00, 8'h00, 16'd2, 1'b0, 0}, '{8'h00, 8'h03, 16'd2, 1'b1, 0},
    '{8'h00, 8'h02, 16'd4, 1'b0, 4}, '{8'h03, 8'h03, 16'd0, 1'b0, 5}};
  logic        clk = 1'b0, rst_b = 1'b0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = '0, char_bits0 = 4'd8, char_bits1 = 4'd8;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, uart_tx_load, comm_mode;
  logic        sync_master = 1'b1;
  logic        sync_rx_only = 1'b0, ch0_direction = 1'b1, ch1_direction = 1'b1, s, t;
  logic [15:0] rx_holding_register = '0, sync_div_ratio = 16'd1, baud_divisor = '0;
  logic [1:0]  rx_done, rx_start_evt, tx_start_evt, tx_end_evt;
  logic [7:0]  rx_data0, rx_data1, buffer_low_byte, buffer_high_byte;
  logic [15:0] tx_shift_register;
  logic        tx_frame_end, gap_tick, sync_load, sync_op_start, sync_length_select;
  logic        sync_serial_start, uart_ch0_start, uart_ch1_start;
  logic        channel0_interrupt, channel1_interrupt, frame_gap_active;
  int          n_fail = 0, compares = 0, irq0 = 0, irq1 = 0, ops = 0, loads = 0, ticks = 0;
  int          c0, c1, sl = 0;
  serial_unit_buffer_mode_interval DUT (.*);
  serial_far_side far (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    irq0 <= irq0 + (channel0_interrupt === 1'b1);
    irq1 <= irq1 + (channel1_interrupt === 1'b1);
    ops <= ops + (sync_op_start === 1'b1);
    sl <= sl + (sync_load === 1'b1);
    loads <= loads + (uart_tx_load !== 2'b00);
    ticks <= ticks + (frame_gap_active === 1'b1 && gap_tick === 1'b1);
  end
  task automatic finish_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    finish_test();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] st);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= {2'b00, st};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [17:0] a, input logic [15:0] e);
    rd(a);
    check(rdat, {16'h0000, e});
    check(rsp, OK);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 2'b11);
      check(rsp, rows[i].r);
      rd(rows[i].a);
      check(rdat, {16'h0000, rows[i].e});
      check(rsp, rows[i].r);
    end
    // Second reset in mid-run returns every register to its reset value
    do_reset();
    rchk(A_MOD, 16'h0000);
    rchk(A_GAP, 16'h0000);
    rchk(A_BUF, 16'h0000);
    check(comm_mode, `CM_SYNC0);
    rx_holding_register <= 16'hbeef;
    wr(A_BUF, 16'h77a5, 2'b01);
    repeat (3) @(posedge clk);
    check(tx_shift_register, 16'h00a5);
    check(ops, 1);
    rchk(A_BUF, 16'h00ef);
    wr(A_CFG, 16'h0008, 2'b01);
    check(sync_length_select, 1'b1);
    wr(A_BUF, 16'h0011, 2'b01);
    repeat (3) @(posedge clk);
    check(ops, 1);
    wr(A_BUF, 16'h2200, 2'b10);
    repeat (3) @(posedge clk);
    check(ops, 2);
    check(tx_shift_register, 16'h2211);
    check(sl, 3);
    rchk(A_BUF, 16'hbeef);
    c0 = irq0;
    far.evt(2, 0, 8'h00);
    far.evt(0, 0, 8'h00);
    repeat (3) @(posedge clk);
    check(irq0 - c0, 1);
    for (int i = 0; i < 4; i++) begin
      {s, t} = i[1:0];
      wr(A_MOD, {8'h00, s, t, t, 5'b00010}, 2'b01);
      c0 = irq0;
      c1 = irq1;
      far.evt(2, 0, 8'h00);
      far.evt(3, 0, 8'h00);
      far.evt(1, 0, 8'h00);
      far.evt(0, 0, 8'h5a);
      repeat (3) @(posedge clk);
      check(irq1 - c1, int'(t) + int'(!(s & t)));
      check(irq0 - c0, int'(t) + int'(!(s & t)));
    end
    check(buffer_low_byte, 8'h5a);
    wr(A_BUF, 16'h3c77, 2'b11);
    rchk(A_BUF, 16'h3c5a);
    check(loads, 1);
    char_bits0 <= 4'd5;
    char_bits1 <= 4'd5;
    far.evt(0, 0, 8'hff);
    wr(A_BUF, 16'hff00, 2'b10);
    rchk(A_BUF, 16'h1f1f);
    char_bits0 <= 4'd8;
    char_bits1 <= 4'd8;
    wr(A_MOD, 16'h0003, 2'b01);
    ch0_direction <= 1'b0;
    wr(A_BUF, 16'h1122, 2'b11);
    far.evt(0, 0, 8'h33);
    rchk(A_BUF, 16'h1133);
    check(loads, 3);
    c1 = irq1;
    ch1_direction <= 1'b0;
    far.evt(0, 1, 8'h44);
    rchk(A_BUF, 16'h4433);
    check(buffer_high_byte, 8'h44);
    check(irq1 - c1, 1);
    far.tick_per = 3;
    foreach (gaps[i]) begin
      wr(A_MOD, {8'h00, gaps[i].m}, 2'b01);
      wr(A_GAP, {8'h00, gaps[i].g}, 2'b01);
      sync_div_ratio <= gaps[i].dv;
      baud_divisor <= gaps[i].dv;
      sync_rx_only <= gaps[i].ro;
      c0 = ticks;
      far.evt(4, 0, 8'h00);
      repeat (60) @(posedge clk);
      check(ticks - c0, gaps[i].n);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// >>> sim/serial_unit_checker_asserts.sv
// Port-level assertions for the serial unit front end
`default_nettype none
`include "serial_unit_defs.vh"
module serial_unit_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Register bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Far-side events
  input wire logic [1:0] rx_done,
  input wire logic [7:0] rx_data0,
  input wire logic [1:0] rx_start_evt,
  input wire logic [1:0] tx_start_evt,
  input wire logic [1:0] tx_end_evt,
  input wire logic [3:0] char_bits0,
  input wire logic       tx_frame_end,
  input wire logic       gap_tick,
  // Unit outputs
  input wire logic [1:0] comm_mode,
  input wire logic [7:0] buffer_low_byte,
  input wire logic       sync_load,
  input wire logic       sync_op_start,
  input wire logic       channel0_interrupt,
  input wire logic       channel1_interrupt,
  input wire logic       frame_gap_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // The write and its response land on the same edge, one after the take; the check sees the response one edge later
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  a_irq0_cause: assert property (
    channel0_interrupt |-> $past(rx_done[0] | rx_start_evt[0] | tx_start_evt[0] | tx_end_evt[0]))
    else $error("channel 0 interrupt without event");
  a_irq1_cause: assert property (
    channel1_interrupt |-> $past(rx_done[1] | rx_start_evt[1] | (|tx_start_evt) | (|tx_end_evt)))
    else $error("channel 1 interrupt without event");
  a_rx_store: assert property (
    rx_done[0] && comm_mode == `CM_UART_FULL && char_bits0 >= 4'd8
    |=> buffer_low_byte == $past(rx_data0))
    else $error("received byte not stored");
  a_sync_start: assert property (sync_op_start |-> sync_load && !comm_mode[1])
    else $error("start without sync buffer load");
  a_gap_start: assert property ($rose(frame_gap_active) |-> $past(tx_frame_end))
    else $error("gap began without frame end");
  a_gap_end: assert property ($fell(frame_gap_active) |-> $past(gap_tick))
    else $error("gap ended between ticks");
endmodule
bind serial_unit_buffer_mode_interval serial_unit_checker u_chk (.*);
`default_nettype wire
